// [act_pkg.sv]
// Constants and types shared by the computation and threshold unit.
// Assumes a 32-bit AXI4-Lite bus where each byte register takes one word.
package act_pkg;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [9:0] IDX_LTH  = 10'h3D9;
   localparam logic [9:0] IDX_UTH  = 10'h3DB;
   localparam logic [9:0] IDX_ERR  = 10'h3DD;
   localparam logic [9:0] IDX_SETPOINT_VALUE = 10'h3DF;
   localparam logic [9:0] IDX_FILTER_OUTPUT_VALUE = 10'h3E1;
   localparam logic [9:0] IDX_ACC  = 10'h3E3;
   localparam logic [9:0] IDX_CNT  = 10'h3E6;
   localparam logic [9:0] IDX_RPT  = 10'h3E7;
   localparam logic [9:0] IDX_PREV = 10'h3E8;
   localparam logic [9:0] IDX_RES  = 10'h3EA;
   localparam logic [9:0] IDX_CTRL = 10'h3F5;
   localparam logic [9:0] IDX_ERROR_SELECT_A = 10'h3F6;
   localparam logic [9:0] IDX_STAT = 10'h3F7;
   localparam logic [9:0] IDX_NEXT = 10'h001;
   localparam logic [9:0] IDX_TOP  = 10'h002;

   // Field positions.
   localparam int unsigned FLD_W    = 3;
   localparam int unsigned MD_LSB   = 0;
   localparam int unsigned FM_BIT   = 3;
   localparam int unsigned CRS_LSB  = 4;
   localparam int unsigned PREVIOUS_SOURCE_SELECT_BIT = 7;
   localparam int unsigned TMD_LSB  = 0;
   localparam int unsigned ERROR_SELECT_A_LSB = 4;
   localparam int unsigned GO_BIT   = 0;
   localparam int unsigned BELOW_LOWER_FLAG_BIT = 5;
   localparam int unsigned ABOVE_UPPER_FLAG_BIT = 6;

   // Reset values and limits.
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [7:0]  CNT_ONE  = 8'h01;
   localparam logic [7:0]  CNT_MAX  = 8'hFF;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      ACT_MD_BASIC,
      ACT_MD_ACCUM,
      ACT_MD_AVG,
      ACT_MD_BURST,
      ACT_MD_LPF
   } act_mode_t;

   typedef enum logic [2:0] {
      ACT_ERROR_SELECT_A_RES_PREV,
      ACT_ERROR_SELECT_A_RES_SETPOINT_VALUE,
      ACT_ERROR_SELECT_A_FLT_SETPOINT_VALUE,
      ACT_ERROR_SELECT_A_FLT_PREV
   } act_error_select_a_t;

   typedef enum logic [2:0] {
      ACT_TMD_NEVER,
      ACT_TMD_BELOW,
      ACT_TMD_NOT_BELOW,
      ACT_TMD_OUTSIDE,
      ACT_TMD_INSIDE,
      ACT_TMD_NOT_ABOVE,
      ACT_TMD_ABOVE,
      ACT_TMD_ALWAYS
   } act_tmd_t;

endpackage : act_pkg

// [act_compare.sv]
// Setpoint error and threshold comparison, purely combinational.
// Assumes its inputs come from registers of the enclosing unit.
`timescale 1ns/100ps
module act_compare (
   input  wire logic [15:0] sample,
   input  wire logic [15:0] prevVal,
   input  wire logic [15:0] filterVal,
   input  wire logic [15:0] setpoint,
   input  wire logic [15:0] lowerTh,
   input  wire logic [15:0] upperTh,
   input  wire logic [2:0]  calcSel,
   input  wire logic [2:0]  tmdSel,
   output logic      [15:0] errVal,
   output logic             belowLower,
   output logic             aboveUpper,
   output logic             irqHit
);

   always_comb begin
      // Differences wrap in 16 bits, as the error register is 16 bits wide.
      unique case (act_pkg::act_error_select_a_t'(calcSel))
         act_pkg::ACT_ERROR_SELECT_A_RES_PREV: errVal = sample - prevVal;
         act_pkg::ACT_ERROR_SELECT_A_RES_SETPOINT_VALUE: errVal = sample - setpoint;
         act_pkg::ACT_ERROR_SELECT_A_FLT_SETPOINT_VALUE: errVal = filterVal - setpoint;
         act_pkg::ACT_ERROR_SELECT_A_FLT_PREV: errVal = filterVal - prevVal;
         default: errVal = act_pkg::RST_WORD;
      endcase
      belowLower = $signed(errVal) < $signed(lowerTh);
      aboveUpper = $signed(errVal) > $signed(upperTh);
      unique case (act_pkg::act_tmd_t'(tmdSel))
         act_pkg::ACT_TMD_NEVER:     irqHit = 1'b0;
         act_pkg::ACT_TMD_BELOW:     irqHit = belowLower;
         act_pkg::ACT_TMD_NOT_BELOW: irqHit = !belowLower;
         act_pkg::ACT_TMD_OUTSIDE:   irqHit = belowLower || aboveUpper;
         act_pkg::ACT_TMD_INSIDE:    irqHit = !belowLower && !aboveUpper;
         act_pkg::ACT_TMD_NOT_ABOVE: irqHit = !aboveUpper;
         act_pkg::ACT_TMD_ABOVE:     irqHit = aboveUpper;
         act_pkg::ACT_TMD_ALWAYS:    irqHit = 1'b1;
      endcase
   end

endmodule : act_compare

// [act_unit.sv]
// Computation and threshold unit of a converter, with an AXI4-Lite slave.
// Assumes the converter core drives its strobes on the same clock.
//
// What this block does
// - Software-writable 8-bit repeat setting sets triggers per threshold check.
// - Threshold check happens when the repeat count equals the repeat setting.
// - 8-bit read/write repeat counter tallies triggers; resets to zero.
// - Counter and setting are used only in filter, burst average, average modes.
// - Accumulating modes show accumulator shifted right by shift select as filter.
// - Low-pass mode shows the low-pass result on the filter output.
// - Previous-source select one: previous takes filter output at conversion start.
// - Previous-source select zero: previous takes sample result at conversion start.
// - Previous taken from sample result keeps the result justification format.
// - 18-bit signed accumulator; unused top-byte bits read as sign copies.
// - Accumulator writes are accepted only while no conversion is in progress.
// - 16-bit signed setpoint, reset zero, may enter the error computation.
// - 16-bit signed read-only setpoint error, computed as error select chooses.
// - Error compared to both thresholds sets below-lower and above-upper flags.
// - Threshold interrupt raised from the comparison as interrupt mode selects.
// - Lower and upper thresholds are 16-bit signed read/write, reset zero.
// - Multibyte registers reachable per byte; accumulator top byte holds 17:16.
// - Each sample is held in a 16-bit result register, high and low byte.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/100ps
module act_unit (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic [11:0] awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [11:0] araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        convStart,
   input  wire logic        convDone,
   input  wire logic        convGo,
   input  wire logic [11:0] rawSample,
   output logic             thresholdIrq
);

   typedef struct packed {
      logic [15:0] lower_threshold_value;
      logic [15:0] upper_threshold_value;
      logic [15:0] setpoint_value;
      logic [15:0] err;
      logic [15:0] prev;
      logic [15:0] res;
      logic [17:0] acc;
      logic [7:0]  cnt;
      logic [7:0]  repeat_threshold_value;
      logic [7:0]  ctrl;
      logic [7:0]  error_select_a;
      logic        above;
      logic        below;
      logic        irq;
      logic        pend;
      logic        chk;
      logic        awHeld;
      logic [9:0]  awIdx;
      logic        wHeld;
      logic [7:0]  wByte;
      logic        wLane;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } act_state_t;

   act_state_t          q_r;
   act_state_t          q_nxt;
   act_pkg::act_mode_t  mode;
   logic                counting;
   logic                restart;
   logic [7:0]          cntStep;
   logic [15:0]         newRes;
   logic [17:0]         sampleExt;
   logic [17:0]         accShift;
   logic [15:0]         filterVal;
   logic                doWrite;
   logic                accWrite;
   logic                cntWrite;
   logic [15:0]         cmpErr;
   logic                cmpBelow;
   logic                cmpAbove;
   logic                cmpHit;

   // The two mapped windows are each contiguous, so a range test covers them.
   function automatic logic isMapped(input logic [9:0] idx);
      isMapped = (idx >= act_pkg::IDX_LTH && idx <= act_pkg::IDX_RES + act_pkg::IDX_NEXT)
              || (idx >= act_pkg::IDX_CTRL && idx <= act_pkg::IDX_STAT);
   endfunction : isMapped

   function automatic logic [7:0] readByte(
      input act_state_t  s,
      input logic [9:0]  idx,
      input logic [15:0] flt,
      input logic        go
   );
      readByte = act_pkg::RST_BYTE;
      unique case (idx)
         act_pkg::IDX_LTH:                      readByte = s.lower_threshold_value[7:0];
         act_pkg::IDX_LTH + act_pkg::IDX_NEXT:  readByte = s.lower_threshold_value[15:8];
         act_pkg::IDX_UTH:                      readByte = s.upper_threshold_value[7:0];
         act_pkg::IDX_UTH + act_pkg::IDX_NEXT:  readByte = s.upper_threshold_value[15:8];
         act_pkg::IDX_ERR:                      readByte = s.err[7:0];
         act_pkg::IDX_ERR + act_pkg::IDX_NEXT:  readByte = s.err[15:8];
         act_pkg::IDX_SETPOINT_VALUE:                     readByte = s.setpoint_value[7:0];
         act_pkg::IDX_SETPOINT_VALUE + act_pkg::IDX_NEXT: readByte = s.setpoint_value[15:8];
         act_pkg::IDX_FILTER_OUTPUT_VALUE:                     readByte = flt[7:0];
         act_pkg::IDX_FILTER_OUTPUT_VALUE + act_pkg::IDX_NEXT: readByte = flt[15:8];
         act_pkg::IDX_ACC:                      readByte = s.acc[7:0];
         act_pkg::IDX_ACC + act_pkg::IDX_NEXT:  readByte = s.acc[15:8];
         act_pkg::IDX_ACC + act_pkg::IDX_TOP:   readByte = {{6{s.acc[17]}}, s.acc[17:16]};
         act_pkg::IDX_CNT:                      readByte = s.cnt;
         act_pkg::IDX_RPT:                      readByte = s.repeat_threshold_value;
         act_pkg::IDX_PREV:                     readByte = s.prev[7:0];
         act_pkg::IDX_PREV + act_pkg::IDX_NEXT: readByte = s.prev[15:8];
         act_pkg::IDX_RES:                      readByte = s.res[7:0];
         act_pkg::IDX_RES + act_pkg::IDX_NEXT:  readByte = s.res[15:8];
         act_pkg::IDX_CTRL:                     readByte = s.ctrl;
         act_pkg::IDX_ERROR_SELECT_A:                     readByte = s.error_select_a;
         act_pkg::IDX_STAT: begin
            readByte[act_pkg::ABOVE_UPPER_FLAG_BIT] = s.above;
            readByte[act_pkg::BELOW_LOWER_FLAG_BIT] = s.below;
            readByte[act_pkg::GO_BIT]   = go;
         end
         default: readByte = act_pkg::RST_BYTE;
      endcase
   endfunction : readByte

   act_compare u_compare (
      .sample     (q_r.res),
      .prevVal    (q_r.prev),
      .filterVal  (filterVal),
      .setpoint   (q_r.setpoint_value),
      .lowerTh    (q_r.lower_threshold_value),
      .upperTh    (q_r.upper_threshold_value),
      .calcSel    (q_r.error_select_a[act_pkg::ERROR_SELECT_A_LSB +: act_pkg::FLD_W]),
      .tmdSel     (q_r.error_select_a[act_pkg::TMD_LSB +: act_pkg::FLD_W]),
      .errVal     (cmpErr),
      .belowLower (cmpBelow),
      .aboveUpper (cmpAbove),
      .irqHit     (cmpHit)
   );

   always_comb begin
      q_nxt    = q_r;
      doWrite  = 1'b0;
      mode     = act_pkg::act_mode_t'(q_r.ctrl[act_pkg::MD_LSB +: act_pkg::FLD_W]);
      counting = (mode == act_pkg::ACT_MD_AVG) || (mode == act_pkg::ACT_MD_BURST)
              || (mode == act_pkg::ACT_MD_LPF);

      // Filter output is the shifted accumulator in every mode; the low-pass
      // update below keeps the accumulator at gain two to the shift select.
      accShift  = 18'($signed(q_r.acc) >>> q_r.ctrl[act_pkg::CRS_LSB +: act_pkg::FLD_W]);
      filterVal = accShift[15:0];

      // Justified conversion result: right when the format bit is set.
      if (q_r.ctrl[act_pkg::FM_BIT]) begin
         newRes = {4'h0, rawSample};
      end else begin
         newRes = {rawSample, 4'h0};
      end
      sampleExt = {2'h0, newRes};

      restart = (q_r.cnt == q_r.repeat_threshold_value);
      if (restart) begin
         cntStep = act_pkg::CNT_ONE;
      end else if (q_r.cnt == act_pkg::CNT_MAX) begin
         cntStep = act_pkg::CNT_MAX;
      end else begin
         cntStep = q_r.cnt + act_pkg::CNT_ONE;
      end

      // Write address and data are taken independently, in either order.
      if (awvalid && q_r.awready) begin
         q_nxt.awHeld = 1'b1;
         q_nxt.awIdx  = awaddr[11:2];
      end
      if (wvalid && q_r.wready) begin
         q_nxt.wHeld = 1'b1;
         q_nxt.wByte = wdata[7:0];
         q_nxt.wLane = wstrb[0];
      end

      if (q_r.awHeld && q_r.wHeld && !q_r.bvalid) begin
         doWrite      = 1'b1;
         q_nxt.awHeld = 1'b0;
         q_nxt.wHeld  = 1'b0;
         q_nxt.bvalid = 1'b1;
         q_nxt.bresp  = isMapped(q_r.awIdx) ? act_pkg::RESP_OKAY : act_pkg::RESP_SLVERR;
         if (q_r.wLane) begin
            unique case (q_r.awIdx)
               act_pkg::IDX_LTH:                      q_nxt.lower_threshold_value[7:0]   = q_r.wByte;
               act_pkg::IDX_LTH + act_pkg::IDX_NEXT:  q_nxt.lower_threshold_value[15:8]  = q_r.wByte;
               act_pkg::IDX_UTH:                      q_nxt.upper_threshold_value[7:0]   = q_r.wByte;
               act_pkg::IDX_UTH + act_pkg::IDX_NEXT:  q_nxt.upper_threshold_value[15:8]  = q_r.wByte;
               act_pkg::IDX_SETPOINT_VALUE:                     q_nxt.setpoint_value[7:0]  = q_r.wByte;
               act_pkg::IDX_SETPOINT_VALUE + act_pkg::IDX_NEXT: q_nxt.setpoint_value[15:8] = q_r.wByte;
               act_pkg::IDX_ACC: begin
                  if (!convGo) begin
                     q_nxt.acc[7:0] = q_r.wByte;
                  end
               end
               act_pkg::IDX_ACC + act_pkg::IDX_NEXT: begin
                  if (!convGo) begin
                     q_nxt.acc[15:8] = q_r.wByte;
                  end
               end
               act_pkg::IDX_ACC + act_pkg::IDX_TOP: begin
                  if (!convGo) begin
                     q_nxt.acc[17:16] = q_r.wByte[1:0];
                  end
               end
               act_pkg::IDX_CNT:                      q_nxt.cnt       = q_r.wByte;
               act_pkg::IDX_RPT:                      q_nxt.repeat_threshold_value       = q_r.wByte;
               act_pkg::IDX_RES:                      q_nxt.res[7:0]  = q_r.wByte;
               act_pkg::IDX_RES + act_pkg::IDX_NEXT:  q_nxt.res[15:8] = q_r.wByte;
               act_pkg::IDX_CTRL:                     q_nxt.ctrl      = q_r.wByte;
               act_pkg::IDX_ERROR_SELECT_A:                     q_nxt.error_select_a      = q_r.wByte;
               default: ;
            endcase
         end
      end
      if (q_r.bvalid && bready) begin
         q_nxt.bvalid = 1'b0;
      end

      if (arvalid && q_r.arready) begin
         q_nxt.rvalid = 1'b1;
         q_nxt.rdata  = {24'h000000, readByte(q_r, araddr[11:2], filterVal, convGo)};
         q_nxt.rresp  = isMapped(araddr[11:2]) ? act_pkg::RESP_OKAY : act_pkg::RESP_SLVERR;
      end else if (q_r.rvalid && rready) begin
         q_nxt.rvalid = 1'b0;
      end

      // Hardware updates come after bus writes, so a conversion wins a clash.
      if (convStart) begin
         q_nxt.prev = q_r.ctrl[act_pkg::PREVIOUS_SOURCE_SELECT_BIT] ? filterVal : q_r.res;
      end

      q_nxt.irq  = 1'b0;
      q_nxt.pend = 1'b0;
      if (convDone) begin
         q_nxt.res  = newRes;
         q_nxt.pend = 1'b1;
         q_nxt.chk  = !counting || (cntStep == q_r.repeat_threshold_value);
         if (counting) begin
            q_nxt.cnt = cntStep;
         end
         unique case (mode)
            act_pkg::ACT_MD_BASIC: ;
            act_pkg::ACT_MD_ACCUM: q_nxt.acc = q_r.acc + sampleExt;
            act_pkg::ACT_MD_AVG, act_pkg::ACT_MD_BURST: begin
               // A new repeat cycle starts the sum afresh.
               q_nxt.acc = restart ? sampleExt : q_r.acc + sampleExt;
            end
            act_pkg::ACT_MD_LPF:   q_nxt.acc = q_r.acc - accShift + sampleExt;
            default: ;
         endcase
      end

      // The comparison sees the registers one cycle after the result lands.
      if (q_r.pend) begin
         q_nxt.err = cmpErr;
         if (q_r.chk) begin
            q_nxt.above = cmpAbove;
            q_nxt.below = cmpBelow;
            q_nxt.irq   = cmpHit;
         end
      end

      q_nxt.awready = !q_nxt.awHeld;
      q_nxt.wready  = !q_nxt.wHeld;
      q_nxt.arready = !q_nxt.rvalid;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign accWrite = doWrite && q_r.wLane && q_r.awIdx >= act_pkg::IDX_ACC
                  && q_r.awIdx <= act_pkg::IDX_ACC + act_pkg::IDX_TOP;
   assign cntWrite = doWrite && q_r.wLane && q_r.awIdx == act_pkg::IDX_CNT;

   assign awready      = q_r.awready;
   assign wready       = q_r.wready;
   assign bvalid       = q_r.bvalid;
   assign bresp        = q_r.bresp;
   assign arready      = q_r.arready;
   assign rvalid       = q_r.rvalid;
   assign rdata        = q_r.rdata;
   assign rresp        = q_r.rresp;
   assign thresholdIrq = q_r.irq;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   a_acc_write_go: assert property (accWrite && convGo && !convDone |=> $stable(q_r.acc))
      else $error("Accumulator changed by a write during a conversion.");

   a_cnt_saturate: assert property (convDone && counting && q_r.cnt == act_pkg::CNT_MAX
      && q_r.repeat_threshold_value != act_pkg::CNT_MAX && !cntWrite |=> q_r.cnt == act_pkg::CNT_MAX)
      else $error("Repeat counter wrapped past its maximum.");

   a_cnt_idle_mode: assert property (!counting && !cntWrite |=> $stable(q_r.cnt))
      else $error("Repeat counter moved outside a counting mode.");

   a_check_at_rpt: assert property (convDone && counting && cntStep == q_r.repeat_threshold_value
      |=> q_r.pend && q_r.chk ##1 q_r.above == $past(cmpAbove))
      else $error("Threshold check missed when count reached the setting.");

   a_no_check_early: assert property (convDone && counting && cntStep != q_r.repeat_threshold_value
      |=> ##1 $stable(q_r.above) && $stable(q_r.below) && !q_r.irq)
      else $error("Flags updated before the repeat cycle completed.");

   a_prev_filter: assert property (convStart && q_r.ctrl[act_pkg::PREVIOUS_SOURCE_SELECT_BIT]
      |=> q_r.prev == $past(filterVal))
      else $error("Previous result did not take the filter output.");

   a_prev_sample: assert property (convStart && !q_r.ctrl[act_pkg::PREVIOUS_SOURCE_SELECT_BIT]
      |=> q_r.prev == $past(q_r.res))
      else $error("Previous result did not take the sample result.");

   a_flags_together: assert property (q_r.pend && q_r.chk
      |=> q_r.above == $past(cmpAbove) && q_r.below == $past(cmpBelow))
      else $error("Threshold flags do not match the comparison.");

   a_irq_cause: assert property (thresholdIrq |-> $past(q_r.pend && q_r.chk && cmpHit))
      else $error("Threshold interrupt without a selected comparison outcome.");

   a_acc_sign: assert property (arvalid && arready
      && araddr[11:2] == act_pkg::IDX_ACC + act_pkg::IDX_TOP
      |=> rdata[7:2] == {6{$past(q_r.acc[17])}})
      else $error("Accumulator top byte lacks sign copies.");

   a_write_answer: assert property (q_r.awHeld && q_r.wHeld && !bvalid |=> bvalid [*1])
      else $error("Write response not raised.");

   c_check_done: cover property (q_r.pend && q_r.chk && counting);
   c_irq_fired:  cover property (thresholdIrq);
   c_acc_write:  cover property (accWrite && !convGo);
   c_prev_flt:   cover property (convStart && q_r.ctrl[act_pkg::PREVIOUS_SOURCE_SELECT_BIT]);

endmodule : act_unit

// [act_unit_bench.sv]
// Self-checking bench for the computation and threshold unit.
// Assumes act_pkg and act_unit are compiled first; the bench plays bus master and converter core.
`timescale 1ns/100ps
module act_unit_bench;
   typedef struct packed {
      logic [9:0] idx;
      logic [7:0] wv;
      logic [7:0] rexp;
   } act_bench_row_t;

   localparam logic [1:0] OK  = act_pkg::RESP_OKAY;
   localparam logic [1:0] BAD = act_pkg::RESP_SLVERR;

   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0]  wstrb = 4'h0;
   logic        convStart = 1'b0, convDone = 1'b0, convGo = 1'b0;
   logic [11:0] rawSample = 12'h000;
   logic        awready, wready, bvalid, arready, rvalid, thresholdIrq;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   int          numErrors = 0, checkCount = 0, irqCount = 0, irq0, i;
   logic [7:0]  irqMask = 8'hAA;
   act_bench_row_t rows [12] = '{
      '{act_pkg::IDX_LTH, 8'h34, 8'h34}, '{act_pkg::IDX_LTH + 10'h001, 8'h92, 8'h92},
      '{act_pkg::IDX_UTH, 8'h56, 8'h56}, '{act_pkg::IDX_UTH + 10'h001, 8'h7F, 8'h7F},
      '{act_pkg::IDX_SETPOINT_VALUE, 8'h11, 8'h11}, '{act_pkg::IDX_SETPOINT_VALUE + 10'h001, 8'h80, 8'h80},
      '{act_pkg::IDX_CNT, 8'h5A, 8'h5A}, '{act_pkg::IDX_RPT, 8'hC3, 8'hC3},
      '{act_pkg::IDX_ERR, 8'hAA, 8'h00}, '{act_pkg::IDX_FILTER_OUTPUT_VALUE, 8'hAA, 8'h00},
      '{act_pkg::IDX_PREV, 8'hAA, 8'h00}, '{act_pkg::IDX_RES, 8'h77, 8'h77}};

   act_unit act_unit_i (.clock(clock), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .convStart(convStart), .convDone(convDone), .convGo(convGo), .rawSample(rawSample),
      .thresholdIrq(thresholdIrq));

   initial begin
      forever #5 clock = ~clock;
   end

   // Pulses are counted per edge because the interrupt stands for one cycle only.
   always @(posedge clock) begin
      if (thresholdIrq === 1'b1) irqCount <= irqCount + 1;
   end

   task automatic finalReport;
      if (numErrors == 0 && checkCount > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : finalReport

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checkCount++;
      if (got !== exp) begin
         numErrors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic timeout(input int n);
      if (n == 50) begin
         numErrors++;
         finalReport();
      end
   endtask : timeout

   // Address and data are offered together; each is released at the edge that takes it.
   task automatic wr(input logic [9:0] idx, input logic [7:0] val, input logic [1:0] respExp);
      int n;
      @(posedge clock);
      awaddr  <= {idx, 2'b00};
      awvalid <= 1'b1;
      wdata   <= {24'h000000, val};
      wstrb   <= 4'hF;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clock);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      bready <= 1'b0;
      timeout(n);
      check({30'h0, bresp}, {30'h0, respExp});
   endtask : wr

   task automatic rd(input logic [9:0] idx, input logic [7:0] exp, input logic [1:0] respExp);
      int n;
      @(posedge clock);
      araddr  <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clock);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      rready <= 1'b0;
      timeout(n);
      check(rdata, {24'h000000, exp});
      check({30'h0, rresp}, {30'h0, respExp});
   endtask : rd

   // Three spare edges let the error, flags and interrupt land, and the pulse counter
   // settle, before anything is read or compared.
   task automatic convert(input logic [11:0] raw, input logic isStart);
      @(posedge clock);
      convStart <= isStart;
      convDone  <= ~isStart;
      rawSample <= raw;
      @(posedge clock);
      convStart <= 1'b0;
      convDone  <= 1'b0;
      repeat (3) @(posedge clock);
   endtask : convert

   initial begin
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      repeat (2) @(posedge clock);
      for (i = 0; i < 12; i++) rd(rows[i].idx, 8'h00, OK);
      for (i = 0; i < 12; i++) begin
         wr(rows[i].idx, rows[i].wv, OK);
         rd(rows[i].idx, rows[i].rexp, OK);
      end
      wr(10'h100, 8'h12, BAD);
      rd(10'h100, 8'h00, BAD);
      convGo <= 1'b1;
      wr(act_pkg::IDX_ACC, 8'h55, OK);
      convGo <= 1'b0;
      rd(act_pkg::IDX_ACC, 8'h00, OK);
      wr(act_pkg::IDX_ACC + 10'h002, 8'h02, OK);
      rd(act_pkg::IDX_ACC + 10'h002, 8'hFE, OK);
      wr(act_pkg::IDX_ACC + 10'h002, 8'h01, OK);
      rd(act_pkg::IDX_ACC + 10'h002, 8'h01, OK);
      wr(act_pkg::IDX_ACC + 10'h002, 8'h00, OK);
      wr(act_pkg::IDX_ACC + 10'h001, 8'h01, OK);
      wr(act_pkg::IDX_ACC, 8'h40, OK);
      wr(act_pkg::IDX_CTRL, 8'hA1, OK);
      rd(act_pkg::IDX_FILTER_OUTPUT_VALUE, 8'h50, OK);
      rd(act_pkg::IDX_FILTER_OUTPUT_VALUE + 10'h001, 8'h00, OK);
      convert(12'h000, 1'b1);
      rd(act_pkg::IDX_PREV, 8'h50, OK);
      wr(act_pkg::IDX_CTRL, 8'h0A, OK);
      wr(act_pkg::IDX_RPT, 8'h03, OK);
      wr(act_pkg::IDX_CNT, 8'h00, OK);
      wr(act_pkg::IDX_ERROR_SELECT_A, 8'h17, OK);
      irq0 = irqCount;
      for (i = 1; i <= 3; i++) begin
         convert(12'hABC, 1'b0);
         rd(act_pkg::IDX_CNT, 8'(i), OK);
      end
      check(32'(irqCount - irq0), 32'h00000001);
      convert(12'hABC, 1'b0);
      rd(act_pkg::IDX_CNT, 8'h01, OK);
      rd(act_pkg::IDX_RES, 8'hBC, OK);
      rd(act_pkg::IDX_RES + 10'h001, 8'h0A, OK);
      convert(12'h000, 1'b1);
      rd(act_pkg::IDX_PREV + 10'h001, 8'h0A, OK);
      wr(act_pkg::IDX_CTRL, 8'h02, OK);
      convert(12'hABC, 1'b0);
      rd(act_pkg::IDX_RES, 8'hC0, OK);
      convert(12'h000, 1'b1);
      rd(act_pkg::IDX_PREV + 10'h001, 8'hAB, OK);
      wr(act_pkg::IDX_CTRL, 8'h01, OK);
      wr(act_pkg::IDX_CNT, 8'h07, OK);
      convert(12'h123, 1'b0);
      rd(act_pkg::IDX_CNT, 8'h07, OK);
      wr(act_pkg::IDX_CTRL, 8'h0A, OK);
      wr(act_pkg::IDX_RPT, 8'h00, OK);
      wr(act_pkg::IDX_CNT, 8'hFE, OK);
      repeat (2) convert(12'h123, 1'b0);
      rd(act_pkg::IDX_CNT, 8'hFF, OK);
      wr(act_pkg::IDX_CTRL, 8'h08, OK);
      wr(act_pkg::IDX_SETPOINT_VALUE, 8'h10, OK);
      wr(act_pkg::IDX_SETPOINT_VALUE + 10'h001, 8'h00, OK);
      wr(act_pkg::IDX_LTH, 8'h00, OK);
      wr(act_pkg::IDX_LTH + 10'h001, 8'h01, OK);
      wr(act_pkg::IDX_UTH, 8'h00, OK);
      wr(act_pkg::IDX_UTH + 10'h001, 8'h08, OK);
      for (i = 0; i < 8; i++) begin
         wr(act_pkg::IDX_ERROR_SELECT_A, 8'h10 | 8'(i), OK);
         irq0 = irqCount;
         convert(12'h050, 1'b0);
         check(32'(irqCount - irq0), {31'h0, irqMask[i]});
      end
      rd(act_pkg::IDX_STAT, 8'h20, OK);
      rd(act_pkg::IDX_ERR, 8'h40, OK);
      convert(12'h900, 1'b0);
      rd(act_pkg::IDX_STAT, 8'h40, OK);
      rd(act_pkg::IDX_ERR + 10'h001, 8'h08, OK);
      finalReport();
   end
endmodule : act_unit_bench
